// ---- scr_pkg.sv ----
package scr_pkg;

    // Register offsets on the serial control port.
    localparam logic [14:0] SCR_ADDR_USER_CFG  = 15'h0010;
    localparam logic [14:0] SCR_ADDR_CAPT_CTRL = 15'h0029;
    localparam logic [14:0] SCR_ADDR_CLK_IN    = 15'h002A;
    localparam logic [14:0] SCR_ADDR_NOISE     = 15'h002B;
    localparam logic [14:0] SCR_ADDR_POS_LO    = 15'h002C;
    localparam logic [14:0] SCR_ADDR_POS_MID   = 15'h002D;
    localparam logic [14:0] SCR_ADDR_POS_HI    = 15'h002E;

    // Reset values.
    localparam logic [7:0] SCR_RST_USER_CFG  = 8'h00;
    localparam logic [7:0] SCR_RST_CAPT_CTRL = 8'h80;
    localparam logic [7:0] SCR_RST_CLK_IN    = 8'h00;
    localparam logic [7:0] SCR_RST_NOISE     = 8'h10;

    // Field positions.
    localparam int SCR_BIT_ADDR_HOLD  = 0;
    localparam int SCR_BIT_PROC_EN    = 6;
    localparam int SCR_BIT_RECV_EN    = 5;
    localparam int SCR_BIT_FINE_STEP  = 4;
    localparam int SCR_TAP_MSB        = 3;
    localparam int SCR_BIT_INVERT     = 0;
    localparam int SCR_BIT_SYNC_PECL  = 1;
    localparam int SCR_BIT_CLK_PECL   = 2;
    localparam int SCR_BIT_CLK_RAIL   = 0;
    localparam int SCR_BIT_ANA_RAIL   = 2;

    // Serial frame layout: read flag, 15 address bits, then data bytes.
    localparam logic [4:0] SCR_HDR_BITS = 5'h10;

endpackage : scr_pkg

// ---- scr_sync2.sv ----
`timescale 1ns/1ps

// Two-flop synchroniser for pin inputs.
module scr_sync2 (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Pin in, synchronised level out.
    input  wire logic pin_in,
    output logic      sync_out
);

    // State: first and second stage.
    typedef struct packed {
        logic s1;
        logic s2;
    } scr_sync_t;

    scr_sync_t st_q;
    scr_sync_t st_d;

    // The first stage feeds only the second.
    always_comb begin
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
    end

    // Register both stages.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.s2;

endmodule : scr_sync2

// ---- scr_regs.sv ----
`timescale 1ns/1ps

module scr_regs
    import scr_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Serial control port pins (sampled in the clk_sys domain).
    input  wire logic        port_csn,
    input  wire logic        port_sclk,
    input  wire logic        port_sdi,
    output logic             port_sdo,
    output logic             port_sdo_oe,
    // Address direction from the main configuration register.
    input  wire logic        addr_ascend,
    // Capture position status from the window detector.
    input  wire logic [23:0] sync_capture_position,
    // Sync path controls.
    output logic             sync_processor_enable,
    output logic             sync_receiver_enable,
    output logic             window_fine_step,
    output logic [3:0]       sync_delay_tap_select,
    output logic             sync_polarity_invert,
    output logic             device_clock_pecl_mode,
    output logic             sync_input_pecl_mode,
    output logic             analog_rail_noise_suppress,
    output logic             clock_rail_noise_suppress
);

    // Synchronised pin levels.
    logic            csn_s;     // Select, high while the port is idle.
    logic            sclk_s;    // Serial clock.
    logic            sdi_s;     // Serial data in.
    logic [2:0]      pins_raw;  // Pin levels, ordered select, clock, data.
    wire logic [2:0] pins_s;    // The same levels after two flops.

    assign pins_raw = {port_csn, port_sclk, port_sdi};

    // Each pin passes two flops before any logic reads it; a pin that
    // moves near a clock edge can only unsettle the first stage.
    for (genvar g = 0; g < $bits(pins_raw); g++) begin : g_sync
        scr_sync2 u_sync (
            .clk_sys  (clk_sys),
            .resetn   (resetn),
            .pin_in   (pins_raw[g]),
            .sync_out (pins_s[g])
        );
    end

    // Name the synchronised levels for the framing logic.
    assign csn_s  = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s  = pins_s[0];

    // Whole state of the block.
    typedef struct packed {
        logic        sclk_prev;  // Last synchronised clock level.
        logic [4:0]  bit_cnt;    // Bits seen in current header or byte.
        logic        in_data;    // Header done, data bytes flowing.
        logic        rd;         // Access is a read.
        logic [14:0] addr;       // Current register address.
        logic [7:0]  sh_in;      // Incoming shift register.
        logic [7:0]  sh_out;     // Outgoing shift register.
        logic        sdo;        // Serial data out.
        logic        sdo_oe;     // Serial out enable.
        logic [7:0]  user_cfg;   // User serial configuration.
        logic [7:0]  capt_ctrl;  // Sync capture control.
        logic [7:0]  clk_in;     // Clock input configuration.
        logic [7:0]  noise;      // Supply noise control.
    } scr_state_t;

    // Registered state and its next value.
    scr_state_t st_q;
    scr_state_t st_d;

    // Read mux over the register map.
    function automatic logic [7:0] rd_mux(input scr_state_t s, input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            SCR_ADDR_USER_CFG:  v = s.user_cfg;
            SCR_ADDR_CAPT_CTRL: v = s.capt_ctrl;
            SCR_ADDR_CLK_IN:    v = s.clk_in;
            SCR_ADDR_NOISE:     v = s.noise;
            // Capture position status, low byte at the lowest address.
            SCR_ADDR_POS_LO:    v = sync_capture_position[7:0];
            SCR_ADDR_POS_MID:   v = sync_capture_position[15:8];
            SCR_ADDR_POS_HI:    v = sync_capture_position[23:16];
            // Unmapped addresses read as zero.
            default:            v = 8'h00;
        endcase
        return v;
    endfunction : rd_mux

    // Next address for streaming: hold, ascend or descend.
    function automatic logic [14:0] next_addr(input scr_state_t s);
        logic [14:0] n;
        // Start from the current address so every path assigns n.
        n = s.addr;
        if (s.user_cfg[SCR_BIT_ADDR_HOLD]) begin
            n = s.addr;
        end else if (addr_ascend) begin
            n = s.addr + 15'h0001;
        end else begin
            n = s.addr - 15'h0001;
        end
        return n;
    endfunction : next_addr

    // Helpers of the framing process, all set at its top.
    logic       rise;     // Serial clock went high this cycle.
    logic       fall;     // Serial clock went low this cycle.
    logic [7:0] byte_in;  // Shift register with this bit appended.

    // Serial framing, register writes and read shifting.
    always_comb begin
        st_d      = st_q;
        // Edge detect on the synchronised clock; it resets low, like the idle pin.
        rise      = sclk_s & ~st_q.sclk_prev;
        fall      = ~sclk_s & st_q.sclk_prev;
        // The data bit is taken together with the clock rise it belongs to.
        byte_in   = {st_q.sh_in[6:0], sdi_s};
        st_d.sclk_prev = sclk_s;
        if (csn_s) begin
            // Deselected: frame ends, output released.
            st_d.bit_cnt = 5'h00;
            st_d.in_data = 1'b0;
            st_d.sdo_oe  = 1'b0;
            st_d.sdo     = 1'b0;
        end else if (rise) begin
            // Every rise shifts one bit in and counts it.
            st_d.sh_in   = byte_in;
            st_d.bit_cnt = st_q.bit_cnt + 5'h01;
            if (!st_q.in_data) begin
                // Header: read flag then address, MSB first.
                if (st_q.bit_cnt == 5'h00) begin
                    st_d.rd = sdi_s;
                end else begin
                    st_d.addr = {st_q.addr[13:0], sdi_s};
                end
                // Last header bit: fetch the first read byte from the full address.
                if (st_q.bit_cnt == SCR_HDR_BITS - 5'h01) begin
                    st_d.in_data = 1'b1;
                    st_d.bit_cnt = 5'h00;
                    st_d.sh_out  = rd_mux(st_q, {st_q.addr[13:0], sdi_s});
                end
            end else if (st_q.bit_cnt == 5'h07) begin
                // A full data byte: write it unless the access is a read, then step the address.
                // A byte cut short by the select rising is dropped.
                st_d.bit_cnt = 5'h00;
                if (!st_q.rd) begin
                    unique case (st_q.addr)
                        SCR_ADDR_USER_CFG:  st_d.user_cfg  = byte_in;
                        SCR_ADDR_CAPT_CTRL: st_d.capt_ctrl = byte_in;
                        SCR_ADDR_CLK_IN:    st_d.clk_in    = byte_in;
                        SCR_ADDR_NOISE:     st_d.noise     = byte_in;
                        // Status and unmapped addresses take no write.
                        default:            st_d.noise     = st_q.noise;
                    endcase
                end
                // Hold, ascend or descend, then preload the next read byte.
                st_d.addr   = next_addr(st_q);
                st_d.sh_out = rd_mux(st_q, next_addr(st_q));
            end
        end else if (fall && st_q.in_data && st_q.rd) begin
            // Read data goes out MSB first on the falling edge, three clocks after the pin falls, so with
            // four-clock levels it stands about one system clock before the host samples it at the rise.
            st_d.sdo_oe = 1'b1;
            st_d.sdo    = st_q.sh_out[7];
            st_d.sh_out = {st_q.sh_out[6:0], 1'b0};
        end
    end

    // Register the state; reset loads the power-on defaults.
    // The reset branch assigns constants only.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            // Fields without a default of their own clear to zero.
            st_q           <= '0;
            st_q.user_cfg  <= SCR_RST_USER_CFG;
            st_q.capt_ctrl <= SCR_RST_CAPT_CTRL;
            st_q.clk_in    <= SCR_RST_CLK_IN;
            st_q.noise     <= SCR_RST_NOISE;
        end else begin
            st_q <= st_d;
        end
    end

    // Control outputs come straight from the register flops, so no decode glitch reaches a pin.
    // Serial read driver.
    assign port_sdo                   = st_q.sdo;
    assign port_sdo_oe                = st_q.sdo_oe;
    // Sync capture control fields.
    assign sync_processor_enable      = st_q.capt_ctrl[SCR_BIT_PROC_EN];
    assign sync_receiver_enable       = st_q.capt_ctrl[SCR_BIT_RECV_EN];
    assign window_fine_step           = st_q.capt_ctrl[SCR_BIT_FINE_STEP];
    assign sync_delay_tap_select      = st_q.capt_ctrl[SCR_TAP_MSB:0];
    // Input mode and polarity fields.
    assign sync_polarity_invert       = st_q.clk_in[SCR_BIT_INVERT];
    assign device_clock_pecl_mode     = st_q.clk_in[SCR_BIT_CLK_PECL];
    assign sync_input_pecl_mode       = st_q.clk_in[SCR_BIT_SYNC_PECL];
    // Rail noise suppression controls.
    assign analog_rail_noise_suppress = st_q.noise[SCR_BIT_ANA_RAIL];
    assign clock_rail_noise_suppress  = st_q.noise[SCR_BIT_CLK_RAIL];

endmodule : scr_regs

// ---- scr_regs_monitor.sv ----
`timescale 1ns/1ps

// Checks reset values and that controls stay still while the port is idle.
module scr_regs_monitor (
    // Clock and reset.
    input wire logic       clk_sys,
    input wire logic       resetn,
    // Serial port select and driver enable.
    input wire logic       port_csn,
    input wire logic       port_sdo_oe,
    // Control outputs.
    input wire logic       sync_processor_enable,
    input wire logic       sync_receiver_enable,
    input wire logic       window_fine_step,
    input wire logic [3:0] sync_delay_tap_select,
    input wire logic       sync_polarity_invert,
    input wire logic       device_clock_pecl_mode,
    input wire logic       sync_input_pecl_mode,
    input wire logic       analog_rail_noise_suppress,
    input wire logic       clock_rail_noise_suppress
);
    // All checks share the system clock and the device reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    rst_sync_a: assert property ($rose(resetn) |->
        !sync_processor_enable && !sync_receiver_enable) else $error("sync enables set after reset");
    rst_tap_a: assert property ($rose(resetn) |->
        !window_fine_step && sync_delay_tap_select == 4'h0) else $error("capture fields not cleared by reset");
    rst_clkin_a: assert property ($rose(resetn) |->
        !sync_polarity_invert && !device_clock_pecl_mode && !sync_input_pecl_mode)
        else $error("input modes not cleared by reset");
    rst_noise_a: assert property ($rose(resetn) |->
        !analog_rail_noise_suppress && !clock_rail_noise_suppress)
        else $error("noise controls set after reset");
    idle_sync_a: assert property (port_csn [*6] |->
        $stable({sync_processor_enable, sync_receiver_enable, window_fine_step, sync_delay_tap_select}))
        else $error("sync controls moved while idle");
    idle_clkin_a: assert property (port_csn [*6] |->
        $stable({sync_polarity_invert, device_clock_pecl_mode, sync_input_pecl_mode}))
        else $error("input modes moved while idle");
    idle_noise_a: assert property (port_csn [*6] |->
        $stable({analog_rail_noise_suppress, clock_rail_noise_suppress}))
        else $error("noise controls moved while idle");
    idle_sdo_a: assert property (port_csn [*6] |-> !port_sdo_oe)
        else $error("read driver on while deselected");
endmodule : scr_regs_monitor

bind scr_regs scr_regs_monitor mon (.clk_sys, .resetn, .port_csn, .port_sdo_oe, .sync_processor_enable,
    .sync_receiver_enable, .window_fine_step, .sync_delay_tap_select, .sync_polarity_invert,
    .device_clock_pecl_mode, .sync_input_pecl_mode, .analog_rail_noise_suppress, .clock_rail_noise_suppress);

// ---- scr_host_model.sv ----
`timescale 1ns/1ps

// Serial control host: a 16-bit header, then data bytes, all MSB first.
module scr_host_model (
    // Clock that paces the serial clock.
    input wire logic clk_sys,
    // Serial pins.
    output logic     port_csn,
    output logic     port_sclk,
    output logic     port_sdi,
    input wire logic port_sdo
);
    // Idle bus: deselected, serial clock low.
    initial begin
        port_csn = 1'b1;
        port_sclk = 1'b0;
        port_sdi = 1'b1;
    end
    // Each serial level lasts four system clocks, above the three the port needs.
    task automatic half();
        repeat (4) @(posedge clk_sys);
        #5;
    endtask : half
    // Present one bit, raise the clock and capture the read bit at the rise.
    task automatic bit_io(input logic b, output logic r);
        port_sdi = b;
        half();
        port_sclk = 1'b1;
        r = port_sdo;
        half();
        port_sclk = 1'b0;
    endtask : bit_io
    // One frame of nb bytes taken from the low end of wd; rv collects sdo.
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] wd, input int nb,
                        output logic [15:0] rv);
        logic [15:0] h;
        logic        r;
        h = {rd, a};
        rv = 16'h0000;
        port_csn = 1'b0;
        half();
        for (int i = 15; i >= 0; i--) bit_io(h[i], r);
        for (int i = 8 * nb - 1; i >= 0; i--) begin
            bit_io(wd[i], r);
            rv = {rv[14:0], r};
        end
        half();
        port_csn = 1'b1;
        // A released data line must not keep showing its last bit.
        port_sdi = ~port_sdi;
        half();
    endtask : xfer
endmodule : scr_host_model

// ---- sysref_clock_control_registers_tb.sv ----
`timescale 1ns/1ps

// Drives register frames through the host model and checks pins and read-backs.
module sysref_clock_control_registers_tb;
    import scr_pkg::*;
    logic        clk_sys = 1'b0, resetn = 1'b0, addr_ascend = 1'b1;
    logic        port_csn, port_sclk, port_sdi, port_sdo, port_sdo_oe;
    logic [23:0] sync_capture_position = 24'hA5C33C;
    logic        sync_processor_enable, sync_receiver_enable, window_fine_step, sync_polarity_invert;
    logic        device_clock_pecl_mode, sync_input_pecl_mode, analog_rail_noise_suppress, clock_rail_noise_suppress;
    logic [3:0]  sync_delay_tap_select;
    logic [15:0] rv;
    int          fail_count = 0, comparisons = 0;
    // All control outputs in one word, in the order built by pack.
    wire  [11:0] outs = {sync_processor_enable, sync_receiver_enable, window_fine_step, sync_delay_tap_select,
                         device_clock_pecl_mode, sync_input_pecl_mode, sync_polarity_invert,
                         analog_rail_noise_suppress, clock_rail_noise_suppress};
    always #50 clk_sys = ~clk_sys;
    scr_regs uut (.clk_sys, .resetn, .port_csn, .port_sclk, .port_sdi, .port_sdo, .port_sdo_oe, .addr_ascend,
                  .sync_capture_position, .sync_processor_enable, .sync_receiver_enable, .window_fine_step,
                  .sync_delay_tap_select, .sync_polarity_invert, .device_clock_pecl_mode, .sync_input_pecl_mode,
                  .analog_rail_noise_suppress, .clock_rail_noise_suppress);
    scr_host_model host (.clk_sys, .port_csn, .port_sclk, .port_sdi, .port_sdo);
    // Expected control word from the three register values.
    function automatic logic [11:0] pack(input logic [7:0] cc, input logic [7:0] ci, input logic [7:0] ns);
        return {cc[6:0], ci[2:0], ns[2], ns[0]};
    endfunction : pack
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [14:0] a, input logic [15:0] d, input int nb);
        host.xfer(1'b0, a, d, nb, rv);
    endtask : wr
    task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
        host.xfer(1'b1, a, 16'h0000, 1, rv);
        check("read", 24'(rv[7:0]), 24'(exp));
    endtask : rdc
    // Hold reset for sixteen clocks, then read back every reset value.
    task automatic reset_and_read();
        @(posedge clk_sys);
        #5;
        resetn = 1'b0;
        repeat (16) @(posedge clk_sys);
        #5;
        resetn = 1'b1;
        check("controls", 24'(outs), 24'(pack(8'h80, 8'h00, 8'h10)));
        check("sdo enable", 24'(port_sdo_oe), 24'h000000);
        // Give the pin synchronisers three clocks before the first frame.
        repeat (3) @(posedge clk_sys);
        #5;
        rdc(15'h0010, 8'h00);
        rdc(15'h0029, 8'h80);
        rdc(15'h002A, 8'h00);
        rdc(15'h002B, 8'h10);
    endtask : reset_and_read
    task automatic conclude();
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        reset_and_read();
        for (int i = 0; i < 3; i++) rdc(15'(44 + i), sync_capture_position[8 * i +: 8]);
        // The position status takes no write, and the driver is released after a read.
        wr(15'h002C, 16'h00FF, 1);
        rdc(15'h002C, sync_capture_position[7:0]);
        check("sdo enable", 24'(port_sdo_oe), 24'h000000);
        wr(15'h0029, 16'h00A0, 1); // Receiver first, reserved top bit kept at one.
        check("controls", 24'(outs), 24'(pack(8'hA0, 8'h00, 8'h10)));
        wr(15'h0029, 16'hF507, 2); // Fine steps and tap 5, then 07 to the clock input register.
        check("controls", 24'(outs), 24'(pack(8'hF5, 8'h07, 8'h10)));
        addr_ascend = 1'b0;
        wr(15'h002B, 16'h1502, 2);
        check("controls", 24'(outs), 24'(pack(8'hF5, 8'h02, 8'h15)));
        wr(15'h0010, 16'h0001, 1); // Reserved bits written as zero.
        wr(15'h0029, 16'h8A83, 2);
        rdc(15'h0029, 8'h83);
        rdc(15'h002A, 8'h02);
        rdc(15'h0010, 8'h01);
        reset_and_read();
        conclude();
    end
    // Cut a hang short well beyond the roughly four and a half thousand clocks the tests need.
    initial begin
        repeat (30000) @(posedge clk_sys);
        fail_count++;
        conclude();
    end
endmodule : sysref_clock_control_registers_tb
